/* File: tlci_pkg_mem.sv */
// Purpose: shared constants and the system area memory of the terminal
//          link command interpreter
// Assumes: single clock, asynchronous active-low reset
// Notes:   the package comes first in this file so it compiles first

`timescale 1ns/1ps
`default_nettype none

package tlci_pkg;
    // ****************************************************************
    // apb register map (byte addresses)
    // ****************************************************************
    localparam logic [11:0] ADDR_CMD0   = 12'h000;
    localparam logic [11:0] ADDR_RESP0  = 12'h040;
    localparam logic [11:0] ADDR_CTRL   = 12'h080;
    localparam logic [11:0] ADDR_STATUS = 12'h084;
    localparam logic [11:0] ADDR_CONFIG = 12'h088;
    localparam int          NWORDS      = 16;

    // ****************************************************************
    // field positions
    // ****************************************************************
    localparam int CTRL_REQ     = 0;
    localparam int CTRL_INIT    = 1;
    localparam int CTRL_REFRESH = 2;
    localparam int CTRL_PERDO   = 3;
    localparam int ST_DONE      = 0;
    localparam int ST_ERR       = 1;
    localparam int ST_BUSY      = 2;
    localparam int ST_MODE_LO   = 3;
    localparam int ST_CODE_LO   = 8;
    localparam int CFG_NODES_LO = 0;
    localparam int CFG_OFFLINE  = 4;

    // ****************************************************************
    // commands, modes, limits
    // ****************************************************************
    localparam logic [7:0]  CMD_INIT   = 8'h01;
    localparam logic [7:0]  CMD_RANDW  = 8'h05;
    localparam logic [7:0]  CMD_MON    = 8'h06;
    localparam logic [7:0]  CMD_PERW   = 8'h08;
    localparam logic [1:0]  MODE_CMDMON = 2'h1;
    localparam logic [1:0]  MODE_ORDMON = 2'h2;
    localparam logic [15:0] SYS_ADDR_MAX = 16'h07EF;
    localparam int          SYS_DEPTH    = 2032;
    localparam logic [2:0]  NODES_RESET  = 3'h4;

    // ****************************************************************
    // error codes
    // ****************************************************************
    localparam logic [7:0] ERR_NONE    = 8'h00;
    localparam logic [7:0] ERR_COUNT   = 8'h01;
    localparam logic [7:0] ERR_ADDR    = 8'h02;
    localparam logic [7:0] ERR_CMD     = 8'h03;
    localparam logic [7:0] ERR_INITUSE = 8'h04;
    localparam logic [7:0] ERR_MODE    = 8'h05;
    localparam logic [7:0] ERR_NOMON   = 8'h06;
    localparam logic [7:0] ERR_NOPER   = 8'h07;
    localparam logic [7:0] ERR_PROT    = 8'h08;
    localparam logic [7:0] ERR_OFFLINE = 8'h09;

    typedef enum logic [2:0] {
        S_IDLE  = 3'b000,
        S_CHECK = 3'b001,
        S_WRITE = 3'b010,
        S_READ  = 3'b011,
        S_RWAIT = 3'b100,
        S_CAPT  = 3'b101,
        S_FIN   = 3'b110
    } tlci_state_t;

    typedef enum logic [2:0] {
        OP_NONE  = 3'b000,
        OP_RANDW = 3'b001,
        OP_MON   = 3'b010,
        OP_PERW  = 3'b011,
        OP_REFR  = 3'b100,
        OP_PERDO = 3'b101
    } tlci_op_t;
endpackage : tlci_pkg

module tlci_sysmem #(
    parameter int DEPTH = tlci_pkg::SYS_DEPTH,
    parameter int WIDTH = 16
) (
    // clock
    input  wire logic                     clock,
    // write port
    input  wire logic                     we,
    input  wire logic [$clog2(DEPTH)-1:0] addr,
    input  wire logic [WIDTH-1:0]         wdata,
    // read port, registered
    output logic      [WIDTH-1:0]         rdata
);
    logic [WIDTH-1:0] mem [DEPTH];

    // no reset: plain ram, content undefined until written
    always_ff @(posedge clock) begin
        if (we) begin
            mem[addr] <= wdata;
        end
        rdata <= mem[addr];
    end
endmodule : tlci_sysmem

`default_nettype wire

/* File: tlci_interp.sv */
// Purpose: command interpreter of an intelligent fieldbus node terminal
// Assumes: apb slave, 10 MHz clock, master obeys request ordering
// Notes:   one command at a time; requests while busy are ignored
//
// How it works
// - command word 0: number high, parameter low
// - init low byte: 1 command, 2 ordinary monitor
// - random write is 5, count 1 to 7
// - random write stores address/data pairs from word 1
// - address above 2031 gives error 02
// - writes into link region are refused
// - writes into protected area give error 08
// - register monitor is 6, 1 to 14 addresses
// - periodic write is 8, 1 to 7 addresses
// - bad count gives error 01
// - undefined command gives error 03
// - misused init gives 04, bad mode 05
// - unregistered monitor 06, periodic write 07
// - offline refuses commands with error 09
// - interface fault codes 14 to 19 reported
// - link fault codes 1A to 1E reported
// - numeric content codes 1F to 21 reported
// - command monitor: code to response, error+done
//
// Design decisions made here: the APB slave port and the register offsets.

`timescale 1ns/1ps
`default_nettype none

module tlci_interp
    import tlci_pkg::*;
#(
    parameter logic [15:0] LINK_LO = 16'h0000,
    parameter logic [15:0] LINK_HI = 16'h000F,
    parameter logic [15:0] PROT_LO = 16'h0010,
    parameter logic [15:0] PROT_HI = 16'h001F
) (
    // clock and reset
    input  wire logic        clock,
    input  wire logic        nrst,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // fault reports from link hardware
    input  wire logic        faultStrobe,
    input  wire logic [7:0]  faultCode,
    // flags toward master
    output logic             doneFlag,
    output logic             errFlag
);
    import tlci_pkg::*;

    // ****************************************************************
    // state
    // ****************************************************************
    typedef struct packed {
        tlci_state_t            state;
        tlci_op_t               op;
        logic [3:0]             idx;
        logic [3:0]             cnt;
        logic [15:0][15:0]      cmdW;
        logic [15:0][15:0]      respW;
        logic [13:0][10:0]      monAddr;
        logic [3:0]             monCnt;
        logic [6:0][10:0]       perAddr;
        logic [3:0]             perCnt;
        logic [1:0]             mode;
        logic [2:0]             nodes;
        logic                   offline;
        logic                   done;
        logic                   err;
        logic [7:0]             errCode;
        logic                   memWe;
        logic [10:0]            memAddr;
        logic [15:0]            memWd;
        logic [31:0]            prdata;
        logic                   pready;
        logic                   pslverr;
    } tlci_st_t;

    tlci_st_t    st;
    tlci_st_t    next_st;
    logic [15:0] memRd;

    tlci_sysmem #(
        .DEPTH (SYS_DEPTH),
        .WIDTH (16)
    ) u_mem (
        .clock (clock),
        .we    (st.memWe),
        .addr  (st.memAddr),
        .wdata (st.memWd),
        .rdata (memRd)
    );

    // ****************************************************************
    // helpers
    // ****************************************************************
    function automatic logic [3:0] wrMax(input logic [2:0] n);
        unique case (n)
            3'h2:    wrMax = 4'h3;
            3'h3:    wrMax = 4'h5;
            default: wrMax = 4'h7;
        endcase
    endfunction : wrMax

    function automatic logic [3:0] monMax(input logic [2:0] n);
        unique case (n)
            3'h2:    monMax = 4'h6;
            3'h3:    monMax = 4'hA;
            default: monMax = 4'hE;
        endcase
    endfunction : monMax

    // random write pairs start at word 1, lists start at word 1
    function automatic logic [3:0] addrWord(input tlci_op_t o,
                                            input logic [3:0] i);
        if (o == OP_RANDW) begin
            addrWord = 4'((i << 1) + 4'h1);
        end else begin
            addrWord = 4'(i + 4'h1);
        end
    endfunction : addrWord

    function automatic logic blocked(input logic [15:0] a);
        blocked = (a >= LINK_LO && a <= LINK_HI) ||
                  (a >= PROT_LO && a <= PROT_HI);
    endfunction : blocked

    // ****************************************************************
    // decode of the current bus access
    // ****************************************************************
    logic       setup;
    logic       access;
    logic       mapped;
    logic [5:0] widx;
    logic       ctrlWr;
    logic [7:0] cmdNum;
    logic [7:0] cmdPar;
    logic [3:0] parCnt;
    logic [15:0] chkAddr;

    always_comb begin
        setup   = psel && !penable;
        access  = psel && penable && st.pready;
        widx    = paddr[7:2];
        mapped  = (paddr[1:0] == 2'h0) && (paddr <= ADDR_CONFIG);
        ctrlWr  = access && pwrite && (paddr == ADDR_CTRL) &&
                  (st.state == S_IDLE);
        cmdNum  = st.cmdW[0][15:8];
        cmdPar  = st.cmdW[0][7:0];
        parCnt  = cmdPar[3:0];
        chkAddr = st.cmdW[addrWord(st.op, st.idx)];
    end

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb begin
        next_st         = st;
        next_st.memWe   = 1'b0;
        next_st.pready  = setup;
        next_st.pslverr = setup && !mapped;

        // bus read data taken in the setup cycle, shown in access
        if (setup) begin
            next_st.prdata = 32'h0000_0000;
            if (mapped && paddr < ADDR_RESP0) begin
                next_st.prdata[15:0] = st.cmdW[widx[3:0]];
            end else if (mapped && paddr < ADDR_CTRL) begin
                next_st.prdata[15:0] = st.respW[widx[3:0]];
            end else if (paddr == ADDR_STATUS) begin
                next_st.prdata[ST_DONE] = st.done;
                next_st.prdata[ST_ERR]  = st.err;
                next_st.prdata[ST_BUSY] = (st.state != S_IDLE);
                next_st.prdata[ST_MODE_LO +: 2] = st.mode;
                next_st.prdata[ST_CODE_LO +: 8] = st.errCode;
            end else if (paddr == ADDR_CONFIG) begin
                next_st.prdata[CFG_NODES_LO +: 3] = st.nodes;
                next_st.prdata[CFG_OFFLINE]       = st.offline;
            end
        end

        // bus writes; command words may change only while idle
        if (access && pwrite && mapped) begin
            if (paddr < ADDR_RESP0 && st.state == S_IDLE) begin
                next_st.cmdW[widx[3:0]] = pwdata[15:0];
            end else if (paddr == ADDR_STATUS) begin
                if (pwdata[ST_DONE]) next_st.done = 1'b0;
                if (pwdata[ST_ERR])  next_st.err  = 1'b0;
            end else if (paddr == ADDR_CONFIG) begin
                next_st.nodes   = pwdata[CFG_NODES_LO +: 3];
                next_st.offline = pwdata[CFG_OFFLINE];
            end
        end

        unique case (st.state)
            S_IDLE: begin
                if (ctrlWr && |pwdata[3:0]) begin
                    next_st.done    = 1'b0;
                    next_st.err     = 1'b0;
                    next_st.idx     = 4'h0;
                    next_st.errCode = ERR_NONE;
                    next_st.state   = S_FIN;
                    if (st.offline) begin
                        next_st.errCode = ERR_OFFLINE;
                    end else if (pwdata[CTRL_INIT]) begin
                        if (cmdNum != CMD_INIT) begin
                            next_st.errCode = ERR_INITUSE;
                        end else if (cmdPar == 8'(MODE_CMDMON) ||
                                     cmdPar == 8'(MODE_ORDMON)) begin
                            next_st.mode = cmdPar[1:0];
                        end else begin
                            next_st.errCode = ERR_MODE;
                        end
                    end else if (pwdata[CTRL_REQ]) begin
                        next_st.cnt   = parCnt;
                        next_st.state = S_CHECK;
                        unique case (cmdNum)
                            CMD_RANDW: next_st.op = OP_RANDW;
                            CMD_MON:   next_st.op = OP_MON;
                            CMD_PERW:  next_st.op = OP_PERW;
                            CMD_INIT: begin
                                next_st.state   = S_FIN;
                                next_st.errCode = ERR_INITUSE;
                            end
                            default: begin
                                next_st.state   = S_FIN;
                                next_st.errCode = ERR_CMD;
                            end
                        endcase
                        // limit follows the occupied nodes
                        if (next_st.state == S_CHECK &&
                            (cmdPar == 8'h00 || cmdPar > 8'(
                             (cmdNum == CMD_MON) ? monMax(st.nodes)
                                                 : wrMax(st.nodes)))) begin
                            next_st.state   = S_FIN;
                            next_st.errCode = ERR_COUNT;
                        end
                    end else if (pwdata[CTRL_REFRESH]) begin
                        if (st.monCnt == 4'h0) begin
                            next_st.errCode = ERR_NOMON;
                        end else begin
                            next_st.op    = OP_REFR;
                            next_st.cnt   = st.monCnt;
                            next_st.state = S_READ;
                        end
                    end else begin
                        if (st.perCnt == 4'h0) begin
                            next_st.errCode = ERR_NOPER;
                        end else begin
                            next_st.op    = OP_PERDO;
                            next_st.cnt   = st.perCnt;
                            next_st.state = S_WRITE;
                        end
                    end
                end
            end
            // every address checked before any store happens
            S_CHECK: begin
                next_st.idx = 4'(st.idx + 4'h1);
                if (chkAddr > SYS_ADDR_MAX) begin
                    next_st.state   = S_FIN;
                    next_st.errCode = ERR_ADDR;
                end else if (st.op != OP_MON && blocked(chkAddr)) begin
                    next_st.state   = S_FIN;
                    next_st.errCode = ERR_PROT;
                end else if (st.idx == 4'(st.cnt - 4'h1)) begin
                    next_st.idx = 4'h0;
                    if (st.op == OP_RANDW) begin
                        next_st.state = S_WRITE;
                    end else if (st.op == OP_MON) begin
                        for (int i = 0; i < 14; i++) begin
                            next_st.monAddr[i] = st.cmdW[i + 1][10:0];
                        end
                        next_st.monCnt = st.cnt;
                        next_st.state  = S_FIN;
                    end else begin
                        for (int i = 0; i < 7; i++) begin
                            next_st.perAddr[i] = st.cmdW[i + 1][10:0];
                        end
                        next_st.perCnt = st.cnt;
                        next_st.state  = S_FIN;
                    end
                end
            end
            S_WRITE: begin
                next_st.memWe = 1'b1;
                if (st.op == OP_RANDW) begin
                    next_st.memAddr = st.cmdW[addrWord(OP_RANDW,
                                                       st.idx)][10:0];
                    next_st.memWd   = st.cmdW[4'(addrWord(OP_RANDW,
                                                       st.idx) + 4'h1)];
                end else begin
                    next_st.memAddr = st.perAddr[st.idx[2:0]];
                    next_st.memWd   = st.cmdW[4'(st.idx + 4'h1)];
                end
                next_st.idx = 4'(st.idx + 4'h1);
                if (st.idx == 4'(st.cnt - 4'h1)) begin
                    next_st.state = S_FIN;
                end
            end
            S_READ: begin
                next_st.memAddr = st.monAddr[st.idx];
                next_st.state   = S_RWAIT;
            end
            S_RWAIT: begin
                next_st.state = S_CAPT;
            end
            S_CAPT: begin
                next_st.respW[st.idx] = memRd;
                next_st.idx           = 4'(st.idx + 4'h1);
                next_st.state = (st.idx == 4'(st.cnt - 4'h1)) ? S_FIN
                                                               : S_READ;
            end
            S_FIN: begin
                next_st.done  = 1'b1;
                next_st.state = S_IDLE;
                next_st.op    = OP_NONE;
                if (st.errCode != ERR_NONE) begin
                    next_st.err = 1'b1;
                    if (st.mode == MODE_CMDMON) begin
                        next_st.respW[0] = {8'h00, st.errCode};
                    end
                end
            end
            default: next_st.state = S_IDLE;
        endcase

        // hardware fault report: sets win over a software clear
        if (faultStrobe) begin
            next_st.err     = 1'b1;
            next_st.errCode = faultCode;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            st       <= '0;
            st.nodes <= NODES_RESET;
            st.mode  <= MODE_ORDMON;
            st.state <= S_IDLE;
        end else begin
            st <= next_st;
        end
    end

    always_comb begin
        prdata   = st.prdata;
        pready   = st.pready;
        pslverr  = st.pslverr;
        doneFlag = st.done;
        errFlag  = st.err;
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);

    sequence s_start;
        ctrlWr && pwdata[CTRL_REQ] && !pwdata[CTRL_INIT];
    endsequence

    sequence s_reported(logic [7:0] code);
        ##2 (errFlag && doneFlag && st.errCode == code);
    endsequence

    a_apb_ready: assert property (setup |=> pready && !$past(penable))
        else $error("pready missing after setup");
    a_apb_unmapped: assert property (setup && !mapped |=> pslverr && pready)
        else $error("unmapped access without error");
    a_offline_code: assert property (
        s_start ##0 st.offline |-> s_reported(ERR_OFFLINE))
        else $error("offline request not refused");
    a_undef_cmd: assert property (
        s_start ##0 (!st.offline && cmdNum inside {8'h00, 8'h07, 8'h09})
        |-> s_reported(ERR_CMD))
        else $error("undefined command not reported");
    a_count_zero: assert property (
        s_start ##0 (!st.offline && cmdNum == CMD_RANDW &&
                     cmdPar == 8'h00) |-> s_reported(ERR_COUNT))
        else $error("zero count not refused");
    a_init_misuse: assert property (
        s_start ##0 (!st.offline && cmdNum == CMD_INIT)
        |-> s_reported(ERR_INITUSE))
        else $error("init via request flag not refused");
    a_write_only_ok: assert property (
        st.memWe |-> $past(st.state) == S_WRITE && st.errCode == ERR_NONE)
        else $error("system area written outside write phase");
    a_resp_code: assert property (
        $rose(doneFlag) && errFlag && st.mode == MODE_CMDMON
        |-> st.respW[0][7:0] == st.errCode)
        else $error("error code not loaded in response");
    a_addr_range: assert property (
        st.state == S_CHECK && chkAddr > SYS_ADDR_MAX
        |=> st.state == S_FIN && st.errCode == ERR_ADDR ##1 errFlag)
        else $error("address range not enforced");
    a_link_block: assert property (
        st.state == S_CHECK && st.op != OP_MON && blocked(chkAddr) &&
        chkAddr <= SYS_ADDR_MAX |=> st.errCode == ERR_PROT)
        else $error("protected target accepted");
endmodule : tlci_interp

`default_nettype wire

/* File: tlci_master.sv */
// Purpose: apb master standing in for the fieldbus master unit
// Assumes: tlci_interp slave, one clock, rising edge
// Notes:   signals move only just after a rising edge
`timescale 1ns/1ps
`default_nettype none
module tlci_master (
    // clock
    input  wire logic        clock,
    // apb request
    output var  logic        psel,
    output var  logic        penable,
    output var  logic        pwrite,
    output var  logic [11:0] paddr,
    output var  logic [31:0] pwdata,
    // apb answer
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    initial begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 12'h000;
        pwdata  = 32'h0000_0000;
    end
    // ********************
    // one whole transfer
    // ********************
    // no wait count assumed; a hang is cut by the bench timeout
    task automatic xfer(input logic w, input logic [11:0] a,
                        input logic [31:0] d, output logic [31:0] r,
                        output logic e);
        @(posedge clock);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clock);
        penable <= 1'b1;
        // answer taken at the rising edge where pready stands high
        @(posedge clock);
        while (pready !== 1'b1) @(posedge clock);
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
endmodule : tlci_master
`default_nettype wire

/* File: test_tlci_interp.sv */
// Purpose: self-checking bench of the command interpreter
// Assumes: tlci_master speaks apb, 10 MHz clock
// Notes:   reset, unmapped and empty-list cases first, then table rows, then hand cases in a fixed order
`timescale 1ns/1ps
`default_nettype none
module test_tlci_interp;
    import tlci_pkg::*;
    typedef struct packed {
        logic [63:0] w;
        logic [7:0]  code;
    } tlci_row_t;
    logic        clock = 1'b0;
    logic        nrst, psel, penable, pwrite, pready, pslverr, e;
    logic        faultStrobe, doneFlag, errFlag;
    logic [7:0]  faultCode;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r;
    int          n_fail = 0;
    int          total_checks = 0;
    int          cycles = 0;
    tlci_row_t   rows [11] = '{
        '{64'h0501_0064_1234_0000, ERR_NONE}, '{64'h0500_0064_1234_0000, ERR_COUNT},
        '{64'h0508_0064_1234_0000, ERR_COUNT}, '{64'h0501_07F0_1111_0000, ERR_ADDR},
        '{64'h0501_0005_1111_0000, ERR_PROT}, '{64'h0501_0015_1111_0000, ERR_PROT},
        '{64'h0701_0000_0000_0000, ERR_CMD}, '{64'h0101_0000_0000_0000, ERR_INITUSE},
        '{64'h0601_0064_0000_0000, ERR_NONE}, '{64'h080F_0070_0000_0000, ERR_COUNT},
        '{64'h0801_0070_0000_0000, ERR_NONE}};
    tlci_interp u_tlci_interp (.clock(clock), .nrst(nrst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .faultStrobe(faultStrobe), .faultCode(faultCode),
        .doneFlag(doneFlag), .errFlag(errFlag));
    tlci_master u_tlci_master (.clock(clock), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));
    always #50 clock = ~clock;
    // ceiling well above the few hundred cycles the run needs
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_fail = n_fail + 1;
            test_done();
        end
    end
    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : test_done
    task automatic chk(input string nm, input logic [31:0] x, g);
        total_checks++;
        if (g !== x) begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, x, g);
        end
    endtask : chk
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        u_tlci_master.xfer(1'b1, a, d, r, e);
    endtask : wr
    task automatic rd(input logic [11:0] a);
        u_tlci_master.xfer(1'b0, a, 32'h0, r, e);
    endtask : rd
    // words first, request after; errFlag must follow the code
    task automatic run(input logic [63:0] w, input logic [3:0] c,
                       input logic [7:0] code);
        int k;
        k = 0;
        for (int i = 0; i < 4; i++) wr(12'(4 * i), {16'h0, w[63-16*i -: 16]});
        wr(ADDR_CTRL, {28'h0, c});
        // skip the taking edge: the old done flag still shows there
        do begin
            @(posedge clock);
            k++;
        end while (doneFlag !== 1'b1 && k < 200);
        chk("doneFlag", 32'h1, {31'h0, doneFlag});
        rd(ADDR_STATUS);
        chk("code", {24'h0, code}, {24'h0, r[15:8]});
        chk("errFlag", {31'h0, code != 8'h00}, {31'h0, errFlag});
    endtask : run
    // ********************
    // main sequence
    // ********************
    initial begin
        nrst = 1'b0;
        faultStrobe = 1'b0;
        faultCode = 8'h00;
        repeat (5) @(posedge clock);
        nrst <= 1'b1;
        rd(ADDR_STATUS);
        chk("status reset", 32'h0000_0010, r);
        rd(12'h0C0);
        chk("unmapped", 32'h1, {31'h0, e});
        run(64'h0601_0000_0000_0000, 4'h4, ERR_NOMON);
        run(64'h0601_0000_0000_0000, 4'h8, ERR_NOPER);
        for (int i = 0; i < 11; i++) run(rows[i].w, 4'h1, rows[i].code);
        $display("table rows done");
        run(64'h0, 4'h4, ERR_NONE);
        rd(ADDR_RESP0);
        chk("refresh", 32'h1234, r);
        run(64'h0502_0064_BEEF_07F0, 4'h1, ERR_ADDR);
        run(64'h0, 4'h4, ERR_NONE);
        rd(ADDR_RESP0);
        chk("untouched", 32'h1234, r);
        run(64'h0000_5A5A_0000_0000, 4'h8, ERR_NONE);
        run(64'h0601_0070_0000_0000, 4'h1, ERR_NONE);
        run(64'h0, 4'h4, ERR_NONE);
        rd(ADDR_RESP0);
        chk("periodic", 32'h5A5A, r);
        run(64'h0103_0000_0000_0000, 4'h2, ERR_MODE);
        run(64'h0101_0000_0000_0000, 4'h2, ERR_NONE);
        run(64'h0201_0000_0000_0000, 4'h1, ERR_CMD);
        rd(ADDR_RESP0);
        chk("resp code", 32'h3, r);
        wr(ADDR_CONFIG, 32'h2);
        run(64'h0504_0064_0001_0065, 4'h1, ERR_COUNT);
        run(64'h0603_0064_0065_0066, 4'h1, ERR_NONE);
        wr(ADDR_CONFIG, 32'h12);
        run(64'h0501_0064_0001_0000, 4'h1, ERR_OFFLINE);
        wr(ADDR_STATUS, 32'h3);
        faultStrobe <= 1'b1;
        faultCode <= 8'h1A;
        @(posedge clock);
        faultStrobe <= 1'b0;
        rd(ADDR_STATUS);
        chk("fault", 32'h0000_1A0A, r);
        $display("hand cases done");
        test_done();
    end
endmodule : test_tlci_interp
`default_nettype wire
